// >>> design/sud_top.v
`timescale 1ns/1ps
`default_nettype none
`include "sud_regs.vh"

// Summary of operation
// R1 - Two cascaded block buffers hold user data.
// R2 - Select bit one maps user buffer.
// R3 - Interrupt only when transferred data changed.
// R4 - User buffer always read two bytes.
// R5 - Word interleaves A and B bits.
// R6 - First bit is MSB, bytes in order.
// R7 - Six-word sync code asserts detect.
// R8 - Detect drops after 4096 quiet frames.
// R9 - Non-PCM bit ORs detect and CS bit1.
// R10 - Non-audio passes unmuted; host mutes.
// R11 - Status register reports detected input format.
// R12 - Burst preambles readable in four registers.
// R13 - Lock mode field 00, 01 default, 10.
// R14 - Host matches lock mode to filter.
// R15 - PLL updates only from preambles.
// R16 - Host interprets copy management bits itself.
// R17 - Select bit zero maps channel status buffer.
module sud_top #(
    parameter TIMEOUT_FRAMES = `SUD_NONAUDIO_FRAMES,
    parameter SILENCE_WORDS  = `SUD_SILENCE_WORDS
) (
    input  wire        clk,           // 200 MHz system clock.
    input  wire        resetn,        // Asynchronous reset, active low.
    input  wire        u_valid,       // User bit present.
    input  wire        u_bit,         // User bit value.
    input  wire        u_sub_b,       // User bit from subframe B.
    input  wire        blk_start,     // First frame of a block.
    input  wire        aud_valid,     // Audio word present.
    input  wire [15:0] aud_word,      // Audio word, top 16 bits.
    input  wire        frame_strobe,  // One pulse per frame.
    input  wire        preamble_seen, // Subframe preamble decoded.
    input  wire        cs_bit1,       // Received channel status bit 1.
    input  wire [7:0]  cs_win_data,   // Channel status buffer byte.
    input  wire [7:0]  reg_addr,      // Control port address.
    input  wire        reg_wr,        // Write strobe.
    input  wire [7:0]  reg_wdata,     // Write data.
    input  wire        reg_rd,        // Read strobe.
    output reg  [7:0]  reg_rdata,     // Read data, one cycle after strobe.
    output wire [5:0]  cs_win_index,  // Byte index to status buffer.
    output wire        irq,           // Interrupt, active high level.
    output wire        nonpcm,        // Non-PCM indicator.
    output wire [1:0]  pll_lock_mode, // PLL locking mode.
    output reg         pll_update,    // Lock update pulse to PLL.
    output reg         aud_out_valid, // Audio word forwarded.
    output reg  [15:0] aud_out_word   // Forwarded audio word.
);

    // ****************************************
    // Control registers
    // ****************************************
    reg  [7:0]  ctrl_r;
    reg  [7:0]  mask_r;
    reg         uchg_r;
    wire        buffer_select;
    wire        win_hit;
    wire [7:0]  win_off;
    wire [7:0]  ubuf_byte;
    wire        ubuf_xfer;
    wire        ubuf_changed;
    wire        nonaudio_sync_seen;
    wire        silence;
    wire [31:0] preamble;
    wire [7:0]  fmt_status;
    wire [7:0]  rxcs_status;
    wire        uchg_clear;

    assign buffer_select = ctrl_r[`SUD_CTRL_BUFFER_SELECT_BIT];
    // R13 lock mode field
    assign pll_lock_mode = ctrl_r[`SUD_CTRL_LOCK_LSB +: 2];
    assign win_off       = reg_addr - `SUD_ADDR_WINDOW_BASE;
    assign win_hit       = (reg_addr >= `SUD_ADDR_WINDOW_BASE) &&
                           (win_off < `SUD_WINDOW_BYTES);
    assign cs_win_index  = win_off[5:0];

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ctrl_r <= `SUD_CTRL_RESET;
            mask_r <= `SUD_MASK_RESET;
        end else if (reg_wr) begin
            if (reg_addr == `SUD_ADDR_BUF_CTRL) begin
                ctrl_r <= reg_wdata;
            end
            if (reg_addr == `SUD_ADDR_INT_MASK) begin
                mask_r <= reg_wdata;
            end
        end
    end

    // ****************************************
    // Buffers and detection
    // ****************************************
    // The window index is taken straight from the address, so each byte
    // address returns one half of a word: even is the high byte.
    // R4 two-byte access
    sud_user_buffer u_ubuf (
        .clk       (clk),
        .resetn    (resetn),
        .u_valid   (u_valid),
        .u_bit     (u_bit),
        .u_sub_b   (u_sub_b),
        .blk_start (blk_start),
        .rd_byte   (win_off[5:0]),
        .rd_data_r (ubuf_byte),
        .xfer_r    (ubuf_xfer),
        .changed_r (ubuf_changed)
    );

    sud_sync_detect #(
        .TIMEOUT_FRAMES (TIMEOUT_FRAMES),
        .SILENCE_WORDS  (SILENCE_WORDS)
    ) u_sync (
        .clk          (clk),
        .resetn       (resetn),
        .word_valid   (aud_valid),
        .word         (aud_word),
        .frame_strobe (frame_strobe),
        .detect_r     (nonaudio_sync_seen),
        .silence_r    (silence),
        .preamble_r   (preamble)
    );

    // ****************************************
    // Change event and interrupt
    // ****************************************
    // Reading the event status clears it, but a change arriving in the
    // same cycle is kept so no change goes unreported.
    assign uchg_clear = reg_rd && (reg_addr == `SUD_ADDR_EVENT_STATUS);

    // R3 gated change interrupt
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            uchg_r <= 1'b0;
        end else if (ubuf_changed) begin
            uchg_r <= 1'b1;
        end else if (uchg_clear) begin
            uchg_r <= 1'b0;
        end
    end

    assign irq = uchg_r & mask_r[`SUD_MASK_UCHG_BIT];

    // ****************************************
    // Status views
    // ****************************************
    // Only burst, silence and plain PCM are told apart here; the other
    // encoded format bits read as zero.
    // R11 format report
    assign fmt_status = {1'b0, silence, 4'h0, nonaudio_sync_seen,
                         !nonaudio_sync_seen && !silence};

    // R9 non-PCM OR
    assign nonpcm      = nonaudio_sync_seen | cs_bit1;
    assign rxcs_status = {6'h00, nonpcm, 1'b0};

    // ****************************************
    // Read port
    // ****************************************
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            if (win_hit) begin
                // R2 user window select
                // R17 status window select
                reg_rdata <= buffer_select ? ubuf_byte : cs_win_data;
            end else begin
                case (reg_addr)
                    `SUD_ADDR_FMT_STATUS:   reg_rdata <= fmt_status;
                    // R12 preamble registers
                    `SUD_ADDR_PREAMBLE_0:   reg_rdata <= preamble[31:24];
                    `SUD_ADDR_PREAMBLE_1:   reg_rdata <= preamble[23:16];
                    `SUD_ADDR_PREAMBLE_2:   reg_rdata <= preamble[15:8];
                    `SUD_ADDR_PREAMBLE_3:   reg_rdata <= preamble[7:0];
                    `SUD_ADDR_RX_CHAN_STAT: reg_rdata <= rxcs_status;
                    `SUD_ADDR_EVENT_STATUS: reg_rdata <= {7'h00, uchg_r};
                    `SUD_ADDR_INT_MASK:     reg_rdata <= mask_r;
                    `SUD_ADDR_BUF_CTRL:     reg_rdata <= ctrl_r;
                    default:                reg_rdata <= 8'h00;
                endcase
            end
        end
    end

    // ****************************************
    // Audio path and PLL update
    // ****************************************
    // Data content never reaches the PLL, which keeps recovered timing
    // free of data-dependent jitter.
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pll_update    <= 1'b0;
            aud_out_valid <= 1'b0;
            aud_out_word  <= 16'h0000;
        end else begin
            // R15 preamble-only update
            pll_update    <= preamble_seen;
            // R10 no muting
            aud_out_valid <= aud_valid;
            if (aud_valid) begin
                aud_out_word <= aud_word;
            end
        end
    end

endmodule
`default_nettype wire

// >>> pkg/sud_regs.vh
`ifndef SUD_REGS_VH
`define SUD_REGS_VH

// ****************************************
// Register offsets on the control port
// ****************************************
`define SUD_ADDR_FMT_STATUS   8'h08
`define SUD_ADDR_PREAMBLE_0   8'h09
`define SUD_ADDR_PREAMBLE_1   8'h0a
`define SUD_ADDR_PREAMBLE_2   8'h0b
`define SUD_ADDR_PREAMBLE_3   8'h0c
`define SUD_ADDR_RX_CHAN_STAT 8'h0e
`define SUD_ADDR_EVENT_STATUS 8'h20
`define SUD_ADDR_INT_MASK     8'h21
`define SUD_ADDR_BUF_CTRL     8'h24
`define SUD_ADDR_WINDOW_BASE  8'h4a
`define SUD_WINDOW_BYTES      8'h30

// ****************************************
// Field positions
// ****************************************
`define SUD_CTRL_BUFFER_SELECT_BIT     2
`define SUD_CTRL_LOCK_LSB     4
`define SUD_MASK_UCHG_BIT     0
`define SUD_FMT_PCM_BIT       0
`define SUD_FMT_BURST_BIT     1
`define SUD_FMT_SILENCE_BIT   6
`define SUD_RXCS_NONPCM_BIT   1

// ****************************************
// Reset values and codes
// ****************************************
`define SUD_LOCK_COMPAT       2'h0
`define SUD_LOCK_DEFAULT      2'h1
`define SUD_LOCK_INBAND       2'h2
`define SUD_CTRL_RESET        8'h10
`define SUD_MASK_RESET        8'h00
`define SUD_SYNC_WORD_1       16'hf872
`define SUD_SYNC_WORD_2       16'h4e1f
`define SUD_SYNC_ZERO_WORDS   3'h4

// ****************************************
// Timing counts
// ****************************************
`define SUD_NONAUDIO_FRAMES   4096
`define SUD_SILENCE_WORDS     2048
`define SUD_BLOCK_BITS        384

`endif

// >>> design/sud_user_buffer.v
`timescale 1ns/1ps
`default_nettype none
`include "sud_regs.vh"

module sud_user_buffer #(
    parameter NBITS = `SUD_BLOCK_BITS
) (
    input  wire             clk,        // System clock.
    input  wire             resetn,     // Asynchronous reset, active low.
    input  wire             u_valid,    // One user bit present.
    input  wire             u_bit,      // User bit value.
    input  wire             u_sub_b,    // Bit belongs to subframe B.
    input  wire             blk_start,  // First frame of a block.
    input  wire [5:0]       rd_byte,    // Byte index into readable buffer.
    output reg  [7:0]       rd_data_r,  // Byte read from readable buffer.
    output reg              xfer_r,     // Pulse on staging to readable copy.
    output reg              changed_r   // Pulse when that copy changed data.
);

    reg  [NBITS-1:0] stage_r;
    reg  [NBITS-1:0] read_r;
    reg  [8:0]       idx_r;
    reg              full_r;
    wire [8:0]       idx_now;
    wire [8:0]       pos;
    wire [8:0]       rsel;

    // Subframe B of a frame lands one bit below subframe A.
    assign idx_now = blk_start ? {8'h00, u_sub_b} : idx_r;
    // R5 bit interleave
    // R6 first bit as MSB
    assign pos     = NBITS[8:0] - 9'h001 - idx_now;
    assign rsel    = NBITS[8:0] - 9'h008 - {rd_byte, 3'h0};

    // ****************************************
    // Staging buffer
    // ****************************************
    // R1 staging fill
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            stage_r <= {NBITS{1'b0}};
            idx_r   <= 9'h000;
            full_r  <= 1'b0;
        end else begin
            full_r <= 1'b0;
            if (u_valid) begin
                stage_r[pos] <= u_bit;
                if (idx_now == NBITS[8:0] - 9'h001) begin
                    idx_r  <= 9'h000;
                    full_r <= 1'b1;
                end else begin
                    idx_r <= idx_now + 9'h001;
                end
            end
        end
    end

    // ****************************************
    // Readable buffer
    // ****************************************
    // R1 whole-block copy
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            read_r    <= {NBITS{1'b0}};
            xfer_r    <= 1'b0;
            changed_r <= 1'b0;
        end else begin
            xfer_r    <= full_r;
            // R3 change-only event
            changed_r <= full_r && (stage_r != read_r);
            if (full_r) begin
                read_r <= stage_r;
            end
        end
    end

    // The byte follows the address of the same cycle, so the registered
    // read port above it answers for the address that was strobed.
    // R6 reception order
    always @* begin
        rd_data_r = read_r[rsel +: 8];
    end

endmodule
`default_nettype wire

// >>> design/sud_sync_detect.v
`timescale 1ns/1ps
`default_nettype none
`include "sud_regs.vh"

module sud_sync_detect #(
    parameter TIMEOUT_FRAMES = `SUD_NONAUDIO_FRAMES,
    parameter SILENCE_WORDS  = `SUD_SILENCE_WORDS
) (
    input  wire        clk,          // System clock.
    input  wire        resetn,       // Asynchronous reset, active low.
    input  wire        word_valid,   // Audio word present.
    input  wire [15:0] word,         // Audio word.
    input  wire        frame_strobe, // One pulse per frame.
    output reg         detect_r,     // Non-audio sync seen recently.
    output reg         silence_r,    // Long run of zero words.
    output reg  [31:0] preamble_r    // Burst preambles, first word high.
);

    localparam ST_HUNT = 4'h1;
    localparam ST_SYN2 = 4'h2;
    localparam ST_PRE1 = 4'h4;
    localparam ST_PRE2 = 4'h8;

    reg [3:0]  state_r;
    reg [2:0]  zeros_r;
    reg [12:0] frames_r;
    reg [11:0] quiet_r;
    wire       zero_w = (word == 16'h0000);

    // ****************************************
    // Sync search and preamble capture
    // ****************************************
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_r    <= ST_HUNT;
            zeros_r    <= 3'h0;
            detect_r   <= 1'b0;
            frames_r   <= 13'h0000;
            preamble_r <= 32'h0000_0000;
        end else begin
            // R8 timeout release
            if (frame_strobe && detect_r) begin
                if (frames_r == TIMEOUT_FRAMES[12:0] - 13'h0001) begin
                    detect_r <= 1'b0;
                end else begin
                    frames_r <= frames_r + 13'h0001;
                end
            end
            if (word_valid) begin
                if (zero_w) begin
                    if (zeros_r != `SUD_SYNC_ZERO_WORDS) begin
                        zeros_r <= zeros_r + 3'h1;
                    end
                end else begin
                    zeros_r <= 3'h0;
                end
                case (state_r)
                    ST_HUNT: begin
                        if (zeros_r == `SUD_SYNC_ZERO_WORDS &&
                            word == `SUD_SYNC_WORD_1) begin
                            state_r <= ST_SYN2;
                        end
                    end
                    ST_SYN2: begin
                        // R7 full sync match
                        if (word == `SUD_SYNC_WORD_2) begin
                            state_r  <= ST_PRE1;
                            detect_r <= 1'b1;
                            frames_r <= 13'h0000;
                        end else begin
                            state_r <= ST_HUNT;
                        end
                    end
                    ST_PRE1: begin
                        preamble_r[31:16] <= word;
                        state_r           <= ST_PRE2;
                    end
                    ST_PRE2: begin
                        preamble_r[15:0] <= word;
                        state_r          <= ST_HUNT;
                    end
                    default: begin
                        state_r <= ST_HUNT;
                    end
                endcase
            end
        end
    end

    // ****************************************
    // Digital silence
    // ****************************************
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            quiet_r   <= 12'h000;
            silence_r <= 1'b0;
        end else if (word_valid) begin
            if (!zero_w) begin
                quiet_r   <= 12'h000;
                silence_r <= 1'b0;
            end else if (quiet_r == SILENCE_WORDS[11:0] - 12'h001) begin
                silence_r <= 1'b1;
            end else begin
                quiet_r <= quiet_r + 12'h001;
            end
        end
    end

endmodule
`default_nettype wire

// >>> test/sud_host_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "sud_regs.vh"

// ****************************************
// Host controller on the control port
// ****************************************
module sud_host_model (
    input  wire logic       clk,       // System clock.
    input  wire logic [7:0] reg_rdata, // Read data from the block.
    output var  logic [7:0] reg_addr,  // Address.
    output var  logic       reg_wr,    // Write strobe.
    output var  logic [7:0] reg_wdata, // Write data.
    output var  logic       reg_rd     // Read strobe.
);
    logic [7:0] ctrl_r = `SUD_CTRL_RESET;
    initial begin
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_wdata = 8'h00;
        reg_rd = 1'b0;
    end
    // Released address and data are inverted so stale values cannot pass.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk);
        reg_rd = 1'b0;
        reg_addr = ~a;
        d = reg_rdata;
    endtask
    task automatic set_sel(input logic s);
        ctrl_r[`SUD_CTRL_BUFFER_SELECT_BIT] = s;
        wr(`SUD_ADDR_BUF_CTRL, ctrl_r);
    endtask
    task automatic rd_cs(input logic [5:0] i, output logic [7:0] d);
        set_sel(1'b0);
        rd(`SUD_ADDR_WINDOW_BASE + {2'h0, i}, d);
    endtask
    task automatic set_lock(input logic [1:0] m);
        if (m != 2'h3) begin
            ctrl_r[`SUD_CTRL_LOCK_LSB +: 2] = m;
            wr(`SUD_ADDR_BUF_CTRL, ctrl_r);
        end
    endtask
endmodule
`default_nettype wire

// >>> test/sud_checker_assertions.sv
`timescale 1ns/1ps
`default_nettype none
`include "sud_regs.vh"

// ****************************************
// Port checker
// ****************************************
module sud_checker (
    input wire        clk,           // System clock.
    input wire        resetn,        // Reset, active low.
    input wire        u_valid,       // User bit strobe.
    input wire        aud_valid,     // Audio word strobe.
    input wire [15:0] aud_word,      // Audio word.
    input wire        preamble_seen, // Preamble pulse.
    input wire        cs_bit1,       // Status bit 1.
    input wire [7:0]  reg_addr,      // Address.
    input wire        reg_wr,        // Write strobe.
    input wire [7:0]  reg_wdata,     // Write data.
    input wire        reg_rd,        // Read strobe.
    input wire [5:0]  cs_win_index,  // Window index.
    input wire        irq,           // Interrupt.
    input wire        nonpcm,        // Non-PCM flag.
    input wire [1:0]  pll_lock_mode, // Lock mode.
    input wire        pll_update,    // Lock update.
    input wire        aud_out_valid, // Forwarded strobe.
    input wire [15:0] aud_out_word   // Forwarded word.
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    wire       ctl_wr  = reg_wr && reg_addr == `SUD_ADDR_BUF_CTRL;
    wire       mask_on = reg_wr && reg_addr == `SUD_ADDR_INT_MASK && reg_wdata[0];
    wire       ev_acc  = (reg_rd && reg_addr == `SUD_ADDR_EVENT_STATUS) ||
                         (reg_wr && reg_addr == `SUD_ADDR_INT_MASK);
    wire [7:0] idx     = reg_addr - `SUD_ADDR_WINDOW_BASE;
    AST_NONPCM_OR: assert property (cs_bit1 |-> nonpcm)
        else $error("nonpcm low with status bit 1 set");
    AST_PLL_UPDATE: assert property (preamble_seen |=> pll_update)
        else $error("no lock update after preamble");
    AST_PLL_QUIET: assert property (!preamble_seen |=> !pll_update)
        else $error("lock update without preamble");
    AST_AUD_PASS: assert property (aud_valid |=> aud_out_valid &&
                                   aud_out_word == $past(aud_word))
        else $error("audio word not forwarded unchanged");
    AST_AUD_IDLE: assert property (!aud_valid |=> !aud_out_valid)
        else $error("spurious forwarded word");
    AST_LOCK_WRITE: assert property (ctl_wr |=> pll_lock_mode == $past(reg_wdata[5:4]))
        else $error("lock mode not taken from write");
    AST_LOCK_HOLD: assert property (!ctl_wr |=> $stable(pll_lock_mode))
        else $error("lock mode changed without write");
    AST_CS_INDEX: assert property (cs_win_index == idx[5:0])
        else $error("status window index wrong");
    AST_IRQ_RISE: assert property ($rose(irq) |-> $past(mask_on) || $past(u_valid, 2) ||
                                   $past(u_valid, 3) || $past(u_valid, 4))
        else $error("interrupt without transfer or enable");
    AST_IRQ_FALL: assert property ($fell(irq) |-> $past(ev_acc) || $past(ev_acc, 2))
        else $error("interrupt dropped without clear");
    cover property ($rose(irq));
    cover property (nonpcm && !cs_bit1);
    cover property ($fell(nonpcm));
endmodule

bind sud_top sud_checker chk (.clk(clk), .resetn(resetn), .u_valid(u_valid),
    .aud_valid(aud_valid), .aud_word(aud_word), .preamble_seen(preamble_seen),
    .cs_bit1(cs_bit1), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rd(reg_rd), .cs_win_index(cs_win_index), .irq(irq), .nonpcm(nonpcm),
    .pll_lock_mode(pll_lock_mode), .pll_update(pll_update),
    .aud_out_valid(aud_out_valid), .aud_out_word(aud_out_word));
`default_nettype wire

// >>> test/sud_top_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "sud_regs.vh"

// ****************************************
// Self-checking bench
// ****************************************
module sud_top_bench;
    logic        clk = 1'b0, resetn = 1'b0, u_valid = 1'b0, u_bit = 1'b0;
    logic        u_sub_b = 1'b0, blk_start = 1'b0, aud_valid = 1'b0;
    logic        frame_strobe = 1'b0, preamble_seen = 1'b0, cs_bit1 = 1'b0;
    logic [15:0] aud_word = 16'h0000;
    wire  [7:0]  reg_addr, reg_wdata, reg_rdata, cs_win_data;
    wire         reg_wr, reg_rd, irq, nonpcm, pll_update, aud_out_valid;
    wire  [5:0]  cs_win_index;
    wire  [1:0]  pll_lock_mode;
    wire  [15:0] aud_out_word;
    int          err_total = 0, tests_run = 0;
    logic [7:0]  d;

    always #2.5 clk = ~clk;
    // The neighbour status buffer answers with a byte that encodes its index.
    assign cs_win_data = {2'h3, cs_win_index};

    sud_top #(.TIMEOUT_FRAMES(8), .SILENCE_WORDS(8)) uut (.clk(clk), .resetn(resetn),
        .u_valid(u_valid), .u_bit(u_bit), .u_sub_b(u_sub_b), .blk_start(blk_start),
        .aud_valid(aud_valid), .aud_word(aud_word), .frame_strobe(frame_strobe),
        .preamble_seen(preamble_seen), .cs_bit1(cs_bit1), .cs_win_data(cs_win_data),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .cs_win_index(cs_win_index), .irq(irq), .nonpcm(nonpcm),
        .pll_lock_mode(pll_lock_mode), .pll_update(pll_update),
        .aud_out_valid(aud_out_valid), .aud_out_word(aud_out_word));
    sud_host_model host (.clk(clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd));

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish;
        if (err_total == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    function automatic logic [7:0] pat(input int j, input logic [7:0] s);
        return 8'(j * 37) ^ s;
    endfunction
    // Bits go out A then B per frame, so bit n lands in byte n/8 from the top.
    task automatic send_block(input logic [7:0] s);
        logic [7:0] b;
        for (int n = 0; n < 384; n++) begin
            @(negedge clk);
            b = pat(n / 8, s);
            u_valid = 1'b1;
            u_bit = b[7 - n % 8];
            u_sub_b = n[0];
            blk_start = (n < 2);
        end
        @(negedge clk);
        u_valid = 1'b0;
        blk_start = 1'b0;
        repeat (5) @(negedge clk);
    endtask
    task automatic send_word(input logic [15:0] w);
        @(negedge clk);
        aud_valid = 1'b1;
        aud_word = w;
        preamble_seen = 1'b1;
        @(negedge clk);
        aud_valid = 1'b0;
        aud_word = ~w;
        preamble_seen = 1'b0;
    endtask
    task automatic send_sync;
        logic [15:0] w[8] = '{16'h0, 16'h0, 16'h0, 16'h0, `SUD_SYNC_WORD_1,
                              `SUD_SYNC_WORD_2, 16'h1357, 16'h9bdf};
        foreach (w[i]) send_word(w[i]);
    endtask
    task automatic strobe(input int n);
        repeat (n) begin
            @(negedge clk);
            frame_strobe = 1'b1;
            @(negedge clk);
            frame_strobe = 1'b0;
        end
    endtask

    task automatic t_reset_values;
        host.rd(`SUD_ADDR_BUF_CTRL, d);
        check(d, `SUD_CTRL_RESET);
        check(pll_lock_mode, `SUD_LOCK_DEFAULT);
        host.rd(`SUD_ADDR_INT_MASK, d);
        check(d, `SUD_MASK_RESET);
        host.rd(8'h00, d);
        check(d, 8'h00);
    endtask
    task automatic t_lock_modes;
        logic [1:0] m[3] = '{`SUD_LOCK_COMPAT, `SUD_LOCK_INBAND, `SUD_LOCK_DEFAULT};
        foreach (m[i]) begin
            host.set_lock(m[i]);
            check(pll_lock_mode, m[i]);
            host.rd(`SUD_ADDR_BUF_CTRL, d);
            check(d[5:4], m[i]);
        end
    endtask
    task automatic t_user_data;
        host.wr(`SUD_ADDR_INT_MASK, 8'h01);
        send_block(8'h5a);
        check(irq, 1'b1);
        host.rd(`SUD_ADDR_EVENT_STATUS, d);
        check(d[0], 1'b1);
        check(irq, 1'b0);
        send_block(8'h5a);
        check(irq, 1'b0);
        host.set_sel(1'b1);
        for (int j = 0; j < 48; j++) begin
            host.rd(`SUD_ADDR_WINDOW_BASE + 8'(j), d);
            check(d, pat(j, 8'h5a));
        end
        host.rd_cs(6'h05, d);
        check(d, 8'hc5);
        host.wr(`SUD_ADDR_INT_MASK, 8'h00);
        send_block(8'ha5);
        check(irq, 1'b0);
        host.rd(`SUD_ADDR_EVENT_STATUS, d);
        check(d[0], 1'b1);
    endtask
    task automatic t_format;
        repeat (8) send_word(16'h0000);
        host.rd(`SUD_ADDR_FMT_STATUS, d);
        check(d[6], 1'b1);
        send_word(16'h1234);
        host.rd(`SUD_ADDR_FMT_STATUS, d);
        check({d[6], d[0]}, 2'h1);
    endtask
    task automatic t_sync;
        logic [7:0] p[4] = '{8'h13, 8'h57, 8'h9b, 8'hdf};
        send_sync();
        check(nonpcm, 1'b1);
        foreach (p[i]) begin
            host.rd(`SUD_ADDR_PREAMBLE_0 + 8'(i), d);
            check(d, p[i]);
        end
        host.rd(`SUD_ADDR_FMT_STATUS, d);
        check(d[1], 1'b1);
        host.rd(`SUD_ADDR_RX_CHAN_STAT, d);
        check(d[1], 1'b1);
        strobe(7);
        check(nonpcm, 1'b1);
        strobe(1);
        check(nonpcm, 1'b0);
        send_sync();
        check(nonpcm, 1'b1);
        strobe(8);
        cs_bit1 = 1'b1;
        #1 check(nonpcm, 1'b1);
        @(negedge clk);
        cs_bit1 = 1'b0;
    endtask

    initial begin
        repeat (16) @(negedge clk);
        resetn = 1'b1;
        t_reset_values();
        t_lock_modes();
        t_user_data();
        t_format();
        t_sync();
        tally_and_finish();
    end
    initial begin
        #100000;
        err_total++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
